// ### spp_cfg.svh
/*
 * Constants of the shared pin port: register offsets, implemented-bit masks
 * and reset values. Assumes a 32-bit AHB-Lite register bus and two 16-bit ports.
 */
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

// Port register offsets within one port's window
`define SPP_OFS_DIR        8'h00
`define SPP_OFS_LAT        8'h04
`define SPP_OFS_PIN        8'h08
`define SPP_OFS_ODC        8'h0c
`define SPP_PORT_STRIDE    8'h20
// Analog select registers
`define SPP_OFS_FIRST_PORT_ANALOG_SELECT       8'h40
`define SPP_OFS_SECOND_PORT_ANALOG_SELECT       8'h44

// Implemented port bits, full variant and 20-pin variant
`define SPP_PA_IMPL        16'h00ff
`define SPP_PA_IMPL_20     16'h00ef
`define SPP_PB_IMPL        16'hffff
`define SPP_PB_IMPL_20     16'hff97
// Implemented analog select bits
`define SPP_FIRST_PORT_ANALOG_SELECT_IMPL      16'h001f
`define SPP_FIRST_PORT_ANALOG_SELECT_IMPL_20   16'h000f
`define SPP_SECOND_PORT_ANALOG_SELECT_IMPL      16'hf3ff
`define SPP_SECOND_PORT_ANALOG_SELECT_IMPL_20   16'hf397

// Reset values
`define SPP_DIR_RST        16'hffff
`define SPP_LAT_RST        16'h0000
`define SPP_ODC_RST        16'h0000
`define SPP_ANS_RST        16'hffff

// AHB encodings
`define SPP_HTRANS_NONSEQ  2'h2
`define SPP_HTRANS_SEQ     2'h3

`endif

// ### spp_pins.sv
/* Board model: resolves each pin from the port pads and an outside driver.
   Assumes every pin has a board pull-up; on a clash the port's drive wins. */
module spp_pins (
	input wire spp_pkg::spp_pad_t [1:0] pad,     // Port pad drive
	input wire logic [1:0][15:0]        ext_drv, // Board drives the pin
	input wire logic [1:0][15:0]        ext_val, // Board level
	output logic [1:0][15:0]            pin_in   // Resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	// Port first, then the board, else the pull-up so a released pin never keeps its last value
	always_comb
	begin
		for (int p = 0; p < 2; p++)
			pin_in[p] = (~pad[p].oe_n & pad[p].out) | (pad[p].oe_n & ~(ext_drv[p] & ~ext_val[p]));
	end
endmodule

// ### spp_pkg.sv
/*
 * Types of the shared pin port.
 * Assumes spp_cfg.svh supplies all numeric constants.
 */
package spp_pkg;

	// AHB-Lite request lines from the master
	typedef struct packed {
		logic        hsel;
		logic [31:0] haddr;
		logic [1:0]  htrans;
		logic        hwrite;
		logic [2:0]  hsize;
		logic        hready;
	} spp_ahb_req_t;

	// Register selected by an address
	typedef enum {
		SPP_REG_NONE,
		SPP_REG_DIR,
		SPP_REG_LAT,
		SPP_REG_PIN,
		SPP_REG_ODC,
		SPP_REG_ANS
	} spp_reg_t;

	// Pad drive toward one port's pins
	typedef struct packed {
		logic [15:0] out;
		logic [15:0] oe_n;
	} spp_pad_t;

endpackage

// ### spp_port.sv
/*
 * Shared pin port: two 16-bit parallel ports with direction, latch, pin read,
 * open-drain and analog select, plus output arbitration against peripherals.
 * Assumes one 50 MHz clock, pins and peripheral strobes from outside the clock
 * domain, and an external pad that resolves pin level from out and oe_n.
 */
`include "spp_cfg.svh"

module spp_port #(
	parameter bit VARIANT_20PIN = 1'b0
) (
	input  wire logic                  sys_clk,     // System clock, 50 MHz
	input  wire logic                  rst_n,       // Asynchronous reset, active low
	input  wire spp_pkg::spp_ahb_req_t ahb_req,     // AHB-Lite request lines
	input  wire logic [31:0]           hwdata,      // AHB write data
	output logic [31:0]                hrdata,      // AHB read data
	output logic                       hreadyout,   // AHB ready out
	output logic                       hresp,       // AHB response, always OKAY
	input  wire logic [1:0][15:0]      pin_in,      // Pin levels from the pads
	output spp_pkg::spp_pad_t [1:0]    pad,         // Pad drive per port
	input  wire logic [1:0][15:0]      periph_en,   // Sharing peripheral enabled
	input  wire logic [1:0][15:0]      periph_drv,  // Peripheral actively drives pin
	input  wire logic [1:0][15:0]      periph_out,  // Peripheral output value
	output logic [1:0][15:0]           periph_in,   // Digital input toward peripherals
	output logic [1:0][15:0]           analog_sel   // Analog switch enable per pin
);

	// Implemented mask of a port, for port bits or analog select bits
	function automatic logic [15:0] impl_mask(input logic port_b, input logic ana);
		logic [15:0] m;
		m = 16'h0000;
		if (!ana && !port_b)
			m = VARIANT_20PIN ? `SPP_PA_IMPL_20 : `SPP_PA_IMPL;
		else if (!ana && port_b)
			m = VARIANT_20PIN ? `SPP_PB_IMPL_20 : `SPP_PB_IMPL;
		else if (ana && !port_b)
			m = VARIANT_20PIN ? `SPP_FIRST_PORT_ANALOG_SELECT_IMPL_20 : `SPP_FIRST_PORT_ANALOG_SELECT_IMPL;
		else
			m = VARIANT_20PIN ? `SPP_SECOND_PORT_ANALOG_SELECT_IMPL_20 : `SPP_SECOND_PORT_ANALOG_SELECT_IMPL;
		return m;
	endfunction

	// Address decode shared by read and write paths
	function automatic spp_pkg::spp_reg_t reg_decode(input logic [31:0] a, output logic port_b);
		spp_pkg::spp_reg_t r;
		logic [7:0]        o;
		r      = spp_pkg::SPP_REG_NONE;
		port_b = 1'b0;
		o      = a[7:0];
		if (a[31:8] != 24'h000000)
			r = spp_pkg::SPP_REG_NONE;
		else if (o == `SPP_OFS_FIRST_PORT_ANALOG_SELECT)
			r = spp_pkg::SPP_REG_ANS;
		else if (o == `SPP_OFS_SECOND_PORT_ANALOG_SELECT)
		begin
			r      = spp_pkg::SPP_REG_ANS;
			port_b = 1'b1;
		end
		else if (o < `SPP_OFS_FIRST_PORT_ANALOG_SELECT)
		begin
			port_b = (o >= `SPP_PORT_STRIDE);
			if ({3'h0, o[4:0]} == `SPP_OFS_DIR)
				r = spp_pkg::SPP_REG_DIR;
			else if ({3'h0, o[4:0]} == `SPP_OFS_LAT)
				r = spp_pkg::SPP_REG_LAT;
			else if ({3'h0, o[4:0]} == `SPP_OFS_PIN)
				r = spp_pkg::SPP_REG_PIN;
			else if ({3'h0, o[4:0]} == `SPP_OFS_ODC)
				r = spp_pkg::SPP_REG_ODC;
		end
		return r;
	endfunction

	logic [1:0]             rst_sync_r;
	logic                   rst_int_n;
	logic [1:0][15:0]       pin_meta_r;
	logic [1:0][15:0]       pin_sync_r;
	logic [1:0][15:0]       en_meta_r;
	logic [1:0][15:0]       en_sync_r;
	logic [1:0][15:0]       drv_meta_r;
	logic [1:0][15:0]       drv_sync_r;
	logic [1:0][15:0]       pout_meta_r;
	logic [1:0][15:0]       pout_sync_r;
	logic [1:0][15:0]       dir_r;
	logic [1:0][15:0]       lat_r;
	logic [1:0][15:0]       odc_r;
	logic [1:0][15:0]       ans_r;
	logic                   wr_pend_r;
	spp_pkg::spp_reg_t      wr_reg_r;
	logic                   wr_port_r;
	logic                   acc;
	spp_pkg::spp_reg_t      acc_reg;
	logic                   acc_port;
	logic [31:0]            rd_nxt;
	logic [1:0][15:0]       pin_level;
	logic [1:0][15:0]       wr_val;
	logic                   fwd_hit;
	logic [15:0]            fwd_val;

	// Reset release through two flops so no register leaves reset mid-edge
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			rst_sync_r <= 2'b00;
		else
			rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_int_n = rst_sync_r[1];

	// Two-flop synchronisers on everything arriving from outside the clock
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			pin_meta_r  <= '0;
			pin_sync_r  <= '0;
			en_meta_r   <= '0;
			en_sync_r   <= '0;
			drv_meta_r  <= '0;
			drv_sync_r  <= '0;
			pout_meta_r <= '0;
			pout_sync_r <= '0;
		end
		else
		begin
			pin_meta_r  <= pin_in;
			pin_sync_r  <= pin_meta_r;
			en_meta_r   <= periph_en;
			en_sync_r   <= en_meta_r;
			drv_meta_r  <= periph_drv;
			drv_sync_r  <= drv_meta_r;
			pout_meta_r <= periph_out;
			pout_sync_r <= pout_meta_r;
		end
	end

	// Readable pin level: masked by implemented bits and the analog buffer switch
	always_comb
	begin
		for (int p = 0; p < 2; p++)
			pin_level[p] = pin_sync_r[p] & impl_mask(p[0], 1'b0) & ~ans_r[p];
	end

	// Bus address phase: a valid transfer is taken when hready is high
	always_comb
	begin
		acc      = ahb_req.hsel && ahb_req.hready &&
			(ahb_req.htrans == `SPP_HTRANS_NONSEQ || ahb_req.htrans == `SPP_HTRANS_SEQ);
		acc_reg  = reg_decode(ahb_req.haddr, acc_port);
	end

	// Write still in its data phase, forwarded so that a read in the very next
	// address phase already sees it; without this the read would return the
	// value that the pending write is about to replace
	always_comb
	begin
		fwd_hit = 1'b0;
		fwd_val = 16'h0000;
		if (wr_pend_r && wr_port_r == acc_port)
		begin
			if (acc_reg == spp_pkg::SPP_REG_ANS && wr_reg_r == spp_pkg::SPP_REG_ANS)
			begin
				fwd_hit = 1'b1;
				fwd_val = hwdata[15:0] & impl_mask(wr_port_r, 1'b1);
			end
			else if (acc_reg == spp_pkg::SPP_REG_LAT &&
				(wr_reg_r == spp_pkg::SPP_REG_LAT || wr_reg_r == spp_pkg::SPP_REG_PIN))
			begin
				fwd_hit = 1'b1;
				fwd_val = wr_val[wr_port_r];
			end
			else if ((acc_reg == spp_pkg::SPP_REG_DIR || acc_reg == spp_pkg::SPP_REG_ODC) &&
				wr_reg_r == acc_reg)
			begin
				fwd_hit = 1'b1;
				fwd_val = wr_val[wr_port_r];
			end
		end
	end

	// Read data selected in the address phase, presented in the data phase
	always_comb
	begin
		rd_nxt = 32'h00000000;
		if (acc && !ahb_req.hwrite)
		begin
			case (acc_reg)
				spp_pkg::SPP_REG_DIR: rd_nxt = {16'h0000, dir_r[acc_port]};
				spp_pkg::SPP_REG_LAT: rd_nxt = {16'h0000, lat_r[acc_port]};
				spp_pkg::SPP_REG_PIN: rd_nxt = {16'h0000, pin_level[acc_port]};
				spp_pkg::SPP_REG_ODC: rd_nxt = {16'h0000, odc_r[acc_port]};
				spp_pkg::SPP_REG_ANS: rd_nxt = {16'h0000, ans_r[acc_port]};
				default:              rd_nxt = 32'h00000000;
			endcase
			// A forwarded write overrides the stored value
			if (fwd_hit)
				rd_nxt = {16'h0000, fwd_val};
		end
	end

	// Bus answer: zero wait states, response always OKAY
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			hrdata    <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
		else
		begin
			hrdata    <= rd_nxt;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Write address is held until its data phase brings hwdata
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
		begin
			wr_pend_r <= 1'b0;
			wr_reg_r  <= spp_pkg::SPP_REG_NONE;
			wr_port_r <= 1'b0;
		end
		else
		begin
			wr_pend_r <= acc && ahb_req.hwrite;
			wr_reg_r  <= acc_reg;
			wr_port_r <= acc_port;
		end
	end

	// Written value per port, cut to the implemented bits
	always_comb
	begin
		for (int p = 0; p < 2; p++)
			wr_val[p] = hwdata[15:0] & impl_mask(p[0], 1'b0);
	end

	// Direction registers: all inputs after reset
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
			dir_r <= VARIANT_20PIN ? {`SPP_DIR_RST & `SPP_PB_IMPL_20, `SPP_DIR_RST & `SPP_PA_IMPL_20} :
				{`SPP_DIR_RST & `SPP_PB_IMPL, `SPP_DIR_RST & `SPP_PA_IMPL};
		else if (wr_pend_r && wr_reg_r == spp_pkg::SPP_REG_DIR)
			dir_r[wr_port_r] <= wr_val[wr_port_r];
		else if (VARIANT_20PIN)
			dir_r <= {dir_r[1] & `SPP_PB_IMPL_20, dir_r[0] & `SPP_PA_IMPL_20};
	end

	// Output latches; a pin level write lands here too
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
			lat_r <= {`SPP_LAT_RST, `SPP_LAT_RST};
		else if (wr_pend_r && (wr_reg_r == spp_pkg::SPP_REG_LAT || wr_reg_r == spp_pkg::SPP_REG_PIN))
			lat_r[wr_port_r] <= wr_val[wr_port_r];
	end

	// Open-drain selects
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
			odc_r <= {`SPP_ODC_RST, `SPP_ODC_RST};
		else if (wr_pend_r && wr_reg_r == spp_pkg::SPP_REG_ODC)
			odc_r[wr_port_r] <= wr_val[wr_port_r];
	end

	// Analog selects; unimplemented bits stay zero
	always_ff @(posedge sys_clk or negedge rst_int_n)
	begin
		if (!rst_int_n)
			ans_r <= VARIANT_20PIN ? {`SPP_ANS_RST & `SPP_SECOND_PORT_ANALOG_SELECT_IMPL_20, `SPP_ANS_RST & `SPP_FIRST_PORT_ANALOG_SELECT_IMPL_20} :
				{`SPP_ANS_RST & `SPP_SECOND_PORT_ANALOG_SELECT_IMPL, `SPP_ANS_RST & `SPP_FIRST_PORT_ANALOG_SELECT_IMPL};
		else if (wr_pend_r && wr_reg_r == spp_pkg::SPP_REG_ANS)
			ans_r[wr_port_r] <= hwdata[15:0] & impl_mask(wr_port_r, 1'b1);
		else
			ans_r <= {ans_r[1] & impl_mask(1'b1, 1'b1), ans_r[0] & impl_mask(1'b0, 1'b1)};
	end

	// Pad arbitration, one instance per port; all pad outputs are registered
	genvar gp;
	generate
		for (gp = 0; gp < 2; gp++)
		begin : g_port
			logic [15:0] own_p;
			logic [15:0] port_drv;
			logic [15:0] out_nxt;
			logic [15:0] oe_n_nxt;
			logic [15:0] pin_impl;

			assign pin_impl = impl_mask(1'(gp), 1'b0);
			// Peripheral ownership needs both enable and active drive
			assign own_p    = en_sync_r[gp] & drv_sync_r[gp] & pin_impl;
			// Port drives an output bit it owns; open drain only when the latch is low
			assign port_drv = ~own_p & ~dir_r[gp] & pin_impl &
				(~odc_r[gp] | ~lat_r[gp]);
			assign out_nxt  = (own_p & pout_sync_r[gp]) |
				(~own_p & lat_r[gp] & ~odc_r[gp]);
			assign oe_n_nxt = ~(own_p | port_drv);

			always_ff @(posedge sys_clk or negedge rst_int_n)
			begin
				if (!rst_int_n)
				begin
					pad[gp].out    <= 16'h0000;
					pad[gp].oe_n   <= 16'hffff;
					periph_in[gp]  <= 16'h0000;
					analog_sel[gp] <= 16'h0000;
				end
				else
				begin
					pad[gp].out    <= out_nxt;
					pad[gp].oe_n   <= oe_n_nxt;
					// Bits the port itself drives are blanked where the peripheral is enabled, so its output cannot loop through
					periph_in[gp]  <= pin_sync_r[gp] & ~ans_r[gp] &
						~(port_drv & en_sync_r[gp]);
					analog_sel[gp] <= ans_r[gp];
				end
			end
		end
	endgenerate

endmodule

// ### spp_port_chk.sv
/* Checker of the shared pin port: bus, pad and peripheral-input relations.
   Assumes it is bound to spp_port and uses the constants of spp_cfg.svh. */
`include "spp_cfg.svh"
module spp_port_chk #(
	parameter bit VARIANT_20PIN = 1'b0
) (
	input wire logic                    sys_clk,    // Clock
	input wire logic                    rst_n,      // Reset, active low
	input wire spp_pkg::spp_ahb_req_t   ahb_req,    // Bus request
	input wire logic [31:0]             hrdata,     // Read data
	input wire logic                    hreadyout,  // Ready
	input wire logic                    hresp,      // Response
	input wire spp_pkg::spp_pad_t [1:0] pad,        // Pad drive
	input wire logic [1:0][15:0]        periph_en,  // Peripheral enabled
	input wire logic [1:0][15:0]        periph_drv, // Peripheral drives
	input wire logic [1:0][15:0]        periph_out, // Peripheral value
	input wire logic [1:0][15:0]        periph_in,  // Toward peripherals
	input wire logic [1:0][15:0]        analog_sel  // Analog switches
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] up_r;
	wire logic [15:0] pa_m = VARIANT_20PIN ? `SPP_PA_IMPL_20 : `SPP_PA_IMPL;
	wire logic [15:0] pb_m = VARIANT_20PIN ? `SPP_PB_IMPL_20 : `SPP_PB_IMPL;
	wire logic [15:0] aa_m = VARIANT_20PIN ? `SPP_FIRST_PORT_ANALOG_SELECT_IMPL_20 : `SPP_FIRST_PORT_ANALOG_SELECT_IMPL;
	wire logic [15:0] ab_m = VARIANT_20PIN ? `SPP_SECOND_PORT_ANALOG_SELECT_IMPL_20 : `SPP_SECOND_PORT_ANALOG_SELECT_IMPL;
	wire logic [15:0] own0 = periph_en[0] & periph_drv[0] & pa_m;
	wire logic        live = up_r == 2'h3;
	wire logic        rd_take = ahb_req.hsel && ahb_req.hready && ahb_req.htrans[1] && !ahb_req.hwrite;

	// Edges since release; the internal reset lags rst_n by two edges
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
			up_r <= 2'h0;
		else if (up_r != 2'h3)
			up_r <= up_r + 2'h1;
	end

	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	property p_bus_ok;
		hreadyout && !hresp && hrdata[31:16] == 16'h0;
	endproperty
	a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready, OKAY and 16 bits");
	property p_rd_idle;
		live && !$past(rd_take) |-> hrdata == 32'h0;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data without a read");
	property p_own;
		(live && $stable({own0, periph_out[0]}))[*4] |->
			(pad[0].oe_n & own0) == 16'h0 && ((pad[0].out ^ periph_out[0]) & own0) == 16'h0;
	endproperty
	a_own: assert property (p_own) else $error("driving peripheral not given the pin");
	property p_loop;
		(live && $stable({pad[0], periph_en[0], periph_drv[0]}))[*4] |->
			(periph_in[0] & periph_en[0] & ~periph_drv[0] & ~pad[0].oe_n) == 16'h0;
	endproperty
	a_loop: assert property (p_loop) else $error("port output loops into peripheral");
	property p_ans_in;
		(live && $stable(analog_sel))[*3] |-> (periph_in[0] & analog_sel[0]) == 16'h0
			&& (periph_in[1] & analog_sel[1]) == 16'h0;
	endproperty
	a_ans_in: assert property (p_ans_in) else $error("analog pin seen as digital");
	property p_ans_impl;
		(analog_sel[0] & ~aa_m) == 16'h0 && (analog_sel[1] & ~ab_m) == 16'h0;
	endproperty
	a_ans_impl: assert property (p_ans_impl) else $error("absent analog bit set");
	property p_unimp;
		((~pad[0].oe_n | pad[0].out) & ~pa_m) == 16'h0 && ((~pad[1].oe_n | pad[1].out) & ~pb_m) == 16'h0;
	endproperty
	a_unimp: assert property (p_unimp) else $error("absent pin driven");
	property p_ans_rst;
		$rose(live) |-> ##1 analog_sel[0] == aa_m && analog_sel[1] == ab_m;
	endproperty
	a_ans_rst: assert property (p_ans_rst) else $error("analog select not ones after reset");
endmodule

// ### tb_spp_port.sv
/* Bench of the shared pin port: bus master, board pins and peripherals.
   Assumes the board model spp_pins; a 20-pin copy shares the bus and the pins. */
`include "spp_cfg.svh"
module tb_spp_port;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] P1 = `SPP_PORT_STRIDE;
	logic                    sys_clk = 1'b0;
	logic                    rst_n = 1'b0;
	spp_pkg::spp_ahb_req_t   rq = '0;
	logic [31:0]             hwdata = 32'h0;
	logic [31:0]             hrdata;
	logic                    hreadyout, hresp;
	logic                    rd_ph = 1'b0;
	logic [1:0][15:0]        pin_in, periph_in, analog_sel;
	logic [1:0][15:0]        periph_en = '0, periph_drv = '0, periph_out = '0, ext_drv = '0, ext_val = '0;
	spp_pkg::spp_pad_t [1:0] pad;
	logic [31:0]             exp_q[$];
	logic [15:0]             msk_q[$];
	logic [31:0]             hrdata20, e_now;
	logic [15:0]             r0, r1;
	int                      error_cnt = 0, cmp_count = 0;
	wire spp_pkg::spp_ahb_req_t ahb_req = '{rq.hsel, rq.haddr, rq.htrans, rq.hwrite, rq.hsize, hreadyout};

	always #10 sys_clk = ~sys_clk;
	spp_port dut (.sys_clk, .rst_n, .ahb_req, .hwdata, .hrdata, .hreadyout, .hresp, .pin_in, .pad,
		.periph_en, .periph_drv, .periph_out, .periph_in, .analog_sel);
	spp_pins board (.pad, .ext_drv, .ext_val, .pin_in);
	// 20-pin copy: same requests and pins, only its read data is compared
	spp_port #(.VARIANT_20PIN(1'b1)) dut20 (.sys_clk, .rst_n, .ahb_req, .hwdata, .hrdata(hrdata20),
		.hreadyout(), .hresp(), .pin_in, .pad(), .periph_en, .periph_drv, .periph_out, .periph_in(),
		.analog_sel());

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Bounded wait for hready; a hung bus ends the run
	task automatic wt();
		int n;
		n = 0;
		do
		begin
			@(posedge sys_clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			error_cnt++;
			report_and_stop();
		end
	endtask
	task automatic bus(input logic [7:0] a, input logic w, input logic [15:0] d);
		rq <= '{1'b1, {24'h0, a}, `SPP_HTRANS_NONSEQ, w, 3'h2, 1'b0};
		wt();
		rq <= '0;
		hwdata <= {16'h0, d};
		wt();
	endtask
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		exp_q.push_back({16'h0, e});
		// The 20-pin copy reads the same value less the bits that variant lacks
		msk_q.push_back(a == `SPP_OFS_FIRST_PORT_ANALOG_SELECT ? `SPP_FIRST_PORT_ANALOG_SELECT_IMPL_20 : a == `SPP_OFS_SECOND_PORT_ANALOG_SELECT ? `SPP_SECOND_PORT_ANALOG_SELECT_IMPL_20 :
			a >= P1 ? `SPP_PB_IMPL_20 : `SPP_PA_IMPL_20);
		bus(a, 1'b0, 16'h0);
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		bus(a, 1'b1, d);
		repeat (6) @(posedge sys_clk);
	endtask

	// Data phase of a taken read: oldest note against hrdata
	always @(posedge sys_clk)
	begin
		if (rd_ph)
		begin
			e_now = exp_q.pop_front();
			check("hrdata", hrdata, e_now);
			check("hrdata20", hrdata20, e_now & {16'h0, msk_q.pop_front()});
		end
		rd_ph <= rq.hsel && rq.htrans[1] && !rq.hwrite && hreadyout === 1'b1;
	end

	initial
	begin
		void'($urandom(74944));
		repeat (4) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`SPP_OFS_DIR, `SPP_PA_IMPL);
		rd(P1 + `SPP_OFS_DIR, `SPP_PB_IMPL);
		rd(`SPP_OFS_LAT, 16'h0);
		rd(`SPP_OFS_ODC, 16'h0);
		rd(`SPP_OFS_FIRST_PORT_ANALOG_SELECT, `SPP_FIRST_PORT_ANALOG_SELECT_IMPL);
		rd(`SPP_OFS_SECOND_PORT_ANALOG_SELECT, `SPP_SECOND_PORT_ANALOG_SELECT_IMPL);
		// Board drives random levels on input pins; analog pins read low
		r0 = 16'($urandom);
		r1 = 16'($urandom);
		ext_drv <= '1;
		ext_val <= {r1, r0};
		repeat (6) @(posedge sys_clk);
		rd(`SPP_OFS_PIN, r0 & `SPP_PA_IMPL & ~`SPP_FIRST_PORT_ANALOG_SELECT_IMPL);
		rd(P1 + `SPP_OFS_PIN, r1 & ~`SPP_SECOND_PORT_ANALOG_SELECT_IMPL);
		wr(`SPP_OFS_FIRST_PORT_ANALOG_SELECT, 16'h0);
		wr(`SPP_OFS_SECOND_PORT_ANALOG_SELECT, 16'h0c00);
		rd(`SPP_OFS_SECOND_PORT_ANALOG_SELECT, 16'h0);
		rd(`SPP_OFS_PIN, r0 & `SPP_PA_IMPL);
		rd(P1 + `SPP_OFS_PIN, r1);
		// Port drives through the pin-level address while the board lets go
		ext_drv <= '0;
		r0 = 16'($urandom);
		wr(`SPP_OFS_PIN, r0);
		rd(`SPP_OFS_LAT, r0 & `SPP_PA_IMPL);
		wr(`SPP_OFS_DIR, 16'h000f);
		rd(`SPP_OFS_PIN, r0 & 16'h00f0 | 16'h000f);
		// Open drain releases ones; the board then holds the pins low
		wr(`SPP_OFS_DIR, 16'h0);
		ext_drv <= '1;
		ext_val <= '0;
		wr(`SPP_OFS_ODC, 16'hffff);
		rd(`SPP_OFS_PIN, 16'h0);
		wr(`SPP_OFS_ODC, 16'h0);
		rd(`SPP_OFS_PIN, r0 & `SPP_PA_IMPL);
		// Peripheral drives pins 3:0 and is enabled but idle on 7:4
		wr(`SPP_OFS_LAT, 16'h00ff);
		r1 = 16'($urandom);
		periph_en[0] <= 16'h00ff;
		periph_drv[0] <= 16'h000f;
		periph_out[0] <= r1;
		repeat (6) @(posedge sys_clk);
		rd(`SPP_OFS_PIN, 16'h00f0 | r1 & 16'h000f);
		check("periph_in", periph_in[0], {16'h0, r1 & 16'h000f});
		wr(8'h10, 16'hffff);
		rd(8'h10, 16'h0);
		// Second reset in mid-run restores inputs and analog mode
		rst_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`SPP_OFS_DIR, `SPP_PA_IMPL);
		repeat (2) @(posedge sys_clk);
		report_and_stop();
	end
endmodule

bind spp_port spp_port_chk #(.VARIANT_20PIN(VARIANT_20PIN)) chk (.sys_clk, .rst_n, .ahb_req, .hrdata, .hreadyout,
	.hresp, .pad, .periph_en, .periph_drv, .periph_out, .periph_in, .analog_sel);
